/* File: core/sfq_pkg.sv */
`default_nettype none
package sfq_pkg;
  // instruction codes
  localparam logic [7:0] CMD_NORMAL_READ = 8'h03;
  localparam logic [7:0] CMD_FAST_READ = 8'h0b;
  localparam logic [7:0] CMD_DUAL_IO_READ = 8'hbb;
  localparam logic [7:0] CMD_DUAL_OUTPUT_READ = 8'h3b;
  localparam logic [7:0] CMD_QUAD_OUTPUT_READ = 8'h6b;
  localparam logic [7:0] CMD_QUAD_IO_READ = 8'heb;
  localparam logic [7:0] CMD_DTR_FAST_READ = 8'h0d;
  localparam logic [7:0] CMD_DTR_DUAL_READ = 8'hbd;
  localparam logic [7:0] CMD_DTR_QUAD_READ = 8'hed;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_QUAD_PAGE_PROGRAM_A = 8'h32;
  localparam logic [7:0] CMD_QUAD_PAGE_PROGRAM_B = 8'h38;
  localparam logic [7:0] CMD_SECTOR_ERASE_A = 8'hd7;
  localparam logic [7:0] CMD_SECTOR_ERASE_B = 8'h20;
  localparam logic [7:0] CMD_SMALL_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] CMD_LARGE_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] CMD_WHOLE_ARRAY_ERASE_A = 8'hc7;
  localparam logic [7:0] CMD_WHOLE_ARRAY_ERASE_B = 8'h60;
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_STATUS_READ = 8'h05;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_FUNCTION_READ = 8'h48;
  localparam logic [7:0] CMD_FUNCTION_WRITE = 8'h42;
  localparam logic [7:0] CMD_QUAD_MODE_ENTER = 8'h35;
  localparam logic [7:0] CMD_QUAD_MODE_EXIT = 8'hf5;
  localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
  localparam logic [7:0] CMD_RESET_DO = 8'h99;
  // framing and dummy clock counts
  localparam logic [4:0] ADDR_BITS = 5'd24;
  localparam logic [4:0] BYTE_BITS = 5'd8;
  localparam logic [3:0] DUMMY_FAST = 4'h8;
  localparam logic [3:0] DUMMY_QPI_FAST = 4'h6;
  localparam logic [3:0] DUMMY_DUAL_IO = 4'h4;
  localparam logic [3:0] DUMMY_QUAD_IO = 4'h6;
  localparam logic [3:0] DUMMY_DTR_FAST = 4'h8;
  localparam logic [3:0] DUMMY_DTR_DUAL = 4'h4;
  localparam logic [3:0] DUMMY_DTR_QUAD = 4'h6;
  // erase alignment masks and erased value
  localparam logic [23:0] SECTOR_MASK = 24'hfff000;
  localparam logic [23:0] SMALL_BLOCK_MASK = 24'hff8000;
  localparam logic [23:0] LARGE_BLOCK_MASK = 24'hff0000;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [5:0] STATUS_HI_RESET = 6'h00;
  localparam logic [7:0] FUNCTION_RESET = 8'h00;
  typedef enum logic [3:0] {OP_READ, OP_PROGRAM, OP_SECTOR_ERASE, OP_SMALL_ERASE,
    OP_LARGE_ERASE, OP_WHOLE_ERASE, OP_WRITE_ENABLE, OP_WRITE_DISABLE,
    OP_STATUS_WRITE, OP_FUNCTION_WRITE} sfq_op_type;
  typedef enum {LS_CMD, LS_ADDR, LS_DUMMY, LS_WDATA, LS_RDATA, LS_IGNORE} sfq_state_type;
  typedef enum logic [1:0] {SRC_ARRAY, SRC_STATUS, SRC_FUNCTION} sfq_src_type;
endpackage
`default_nettype wire

/* File: core/sfq_front_end.sv */
`timescale 1ns/10ps
`default_nettype none
// What this block does
// RULE_01: serial mode samples io0 on rising edge
// RULE_02: works with clock idle low or high
// RULE_03: serial mode returns data on io1
// RULE_04: code 35h enters quad command mode
// RULE_05: code f5h leaves quad command mode
// RULE_06: mode switch ignores quad enable bit
// RULE_07: instruction takes eight clocks, or two quad
// RULE_08: exactly one interface mode active at once
// RULE_09: power or software reset returns serial mode
// RULE_10: quad mode uses all four lines bidirectionally
// RULE_11: double rate reads take address on both edges
// RULE_12: dual and quad transfers move more bits
// RULE_13: program takes 1 to 256 bytes per page
// RULE_14: erase sector, small, large block, whole array
// RULE_15: erased array reads back all ones
// RULE_16: reads optionally wrap in 8 to 64 bytes
// RULE_17: read codes 03h, 0bh and bbh
// RULE_18: read codes 3bh, 6bh and ebh
// RULE_19: program codes 02h, 32h and 38h
// RULE_20: erase codes d7h, 20h, 52h, d8h
// RULE_21: codes c7h, 60h, 06h and 04h
// RULE_22: register codes 05h, 01h, 48h, 42h
// RULE_23: deselected device floats outputs, ignores data
// RULE_24: host toggles select low before first instruction
// RULE_25: select rise discards partial instruction
module sfq_front_end
  import sfq_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic [3:0] i_io,
  output logic [3:0] o_io,
  output logic [3:0] o_io_oe_n,
  input wire logic i_busy,
  input wire logic i_wrap_en,
  input wire logic [1:0] i_wrap_len,
  output logic o_op_valid,
  output sfq_op_type o_op_kind,
  output logic [23:0] o_op_addr,
  output logic [7:0] o_op_data,
  output logic o_quad_mode,
  output logic o_write_enabled
);

  function automatic logic [23:0] shin(input logic [23:0] s, input logic [3:0] v,
                                       input logic [2:0] w);
    case (w)
      3'd1: shin = {s[22:0], v[0]};
      3'd2: shin = {s[21:0], v[1:0]};
      default: shin = {s[19:0], v};
    endcase
  endfunction

  logic rst_q;
  logic [2:0] xs1_q, xs2_q;
  logic tgl_old_q;
  logic [3:0] ls1_q, ls2_q;
  logic [3:0] neg_q;
  logic qpi_q, wel_q, arm_q;
  logic [5:0] stat_hi_q;
  logic [7:0] func_q;
  logic ev_tgl_q;
  sfq_op_type ev_kind_q;
  logic [23:0] ev_addr_q;
  logic [7:0] ev_data_q;
  sfq_state_type st_q;
  logic [4:0] cnt_q;
  logic [23:0] sh_q, addr_q;
  logic [2:0] aw_q, dw_q;
  logic dtr_q, first_q, tail_q, rd_q;
  logic [3:0] dum_q;
  sfq_op_type kind_q;
  sfq_src_type src_q;
  logic [7:0] ob_q;
  logic [4:0] rem_q;
  logic [2:0] cw;
  logic [7:0] opc_now;
  logic cmd_done;
  logic d_addr, d_rd, d_wdata, d_fire, d_dtr;
  logic [2:0] d_aw, d_dw;
  logic [3:0] d_dum;
  sfq_op_type d_kind;
  sfq_src_type d_src;
  logic [23:0] sh_n, rd_addr, wrap_next;
  logic [4:0] cnt_n;
  logic addr_done, dtr_tail, rd_start, wb_done, dum_end;
  logic [7:0] wb_n, byte_src, status_byte;
  logic [2:0] dw_eff;
  logic [4:0] step_eff;
  sfq_src_type src_eff;
  logic [5:0] wrap_m;
  logic fire;
  sfq_op_type fire_kind;
  logic [23:0] fire_addr;
  logic [7:0] fire_data;

  // reset flag held on the system side; also clears the link's persistent state
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      rst_q <= 1'b1;
    else if (i_ce)
      rst_q <= 1'b0;
  end

  // levels and event toggle from the link into the system clock
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      xs1_q <= 3'h0;
      xs2_q <= 3'h0;
      tgl_old_q <= 1'b0;
    end
    else if (i_ce)
    begin
      xs1_q <= {ev_tgl_q, qpi_q, wel_q};
      xs2_q <= xs1_q;
      tgl_old_q <= xs2_q[2];
    end
  end

  // event word is quiet long before its toggle is seen here, so it is safe to take
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      o_op_valid <= 1'b0;
      o_op_kind <= OP_READ;
      o_op_addr <= 24'h000000;
      o_op_data <= 8'h00;
      o_quad_mode <= 1'b0;
      o_write_enabled <= 1'b0;
    end
    else if (i_ce)
    begin
      o_op_valid <= xs2_q[2] ^ tgl_old_q;
      if (xs2_q[2] ^ tgl_old_q)
      begin
        o_op_kind <= ev_kind_q;
        o_op_addr <= ev_addr_q;
        o_op_data <= ev_data_q;
      end
      o_quad_mode <= xs2_q[1];
      o_write_enabled <= xs2_q[0];
    end
  end

  // system-side levels into the link clock; only the second stage is read
  always_ff @(posedge i_sck)
  begin
    ls1_q <= {i_busy, i_wrap_en, i_wrap_len};
    ls2_q <= ls1_q;
  end

  // falling-edge sample for double-rate address
  always_ff @(negedge i_sck)
  begin
    neg_q <= i_io; // RULE_11
  end

  // instruction decode
  always_comb
  begin
    cw = qpi_q ? 3'd4 : 3'd1; // RULE_07
    opc_now = qpi_q ? {sh_q[3:0], i_io} : {sh_q[6:0], i_io[0]}; // RULE_01 RULE_10
    cmd_done = (st_q == LS_CMD) && (cnt_q == BYTE_BITS - {2'b00, cw}); // RULE_07
    d_addr = 1'b0;
    d_rd = 1'b0;
    d_wdata = 1'b0;
    d_fire = 1'b0;
    d_dtr = 1'b0;
    d_aw = cw;
    d_dw = cw;
    d_dum = 4'h0;
    d_kind = OP_READ;
    d_src = SRC_ARRAY;
    case (opc_now)
      CMD_NORMAL_READ:
      begin
        d_addr = 1'b1; // RULE_17
        d_rd = 1'b1;
      end
      CMD_FAST_READ:
      begin
        d_addr = 1'b1; // RULE_17
        d_rd = 1'b1;
        d_dum = qpi_q ? DUMMY_QPI_FAST : DUMMY_FAST;
      end
      CMD_DUAL_IO_READ, CMD_DTR_DUAL_READ:
      begin
        d_addr = 1'b1; // RULE_17 RULE_12
        d_rd = 1'b1;
        d_dtr = (opc_now == CMD_DTR_DUAL_READ);
        d_dum = d_dtr ? DUMMY_DTR_DUAL : DUMMY_DUAL_IO;
        if (!qpi_q)
        begin
          d_aw = 3'd2;
          d_dw = 3'd2;
        end
      end
      CMD_DUAL_OUTPUT_READ, CMD_QUAD_OUTPUT_READ:
      begin
        d_addr = 1'b1; // RULE_18 RULE_12
        d_rd = 1'b1;
        d_dum = DUMMY_FAST;
        if (!qpi_q)
          d_dw = (opc_now == CMD_QUAD_OUTPUT_READ) ? 3'd4 : 3'd2;
      end
      CMD_QUAD_IO_READ, CMD_DTR_QUAD_READ:
      begin
        d_addr = 1'b1; // RULE_18 RULE_12
        d_rd = 1'b1;
        d_dtr = (opc_now == CMD_DTR_QUAD_READ);
        d_dum = d_dtr ? DUMMY_DTR_QUAD : DUMMY_QUAD_IO;
        d_aw = 3'd4;
        d_dw = 3'd4;
      end
      CMD_DTR_FAST_READ:
      begin
        d_addr = 1'b1; // RULE_11
        d_rd = 1'b1;
        d_dtr = 1'b1;
        d_dum = DUMMY_DTR_FAST;
      end
      CMD_PAGE_PROGRAM, CMD_QUAD_PAGE_PROGRAM_A, CMD_QUAD_PAGE_PROGRAM_B:
      begin
        d_addr = 1'b1; // RULE_19
        d_kind = OP_PROGRAM;
        if (opc_now != CMD_PAGE_PROGRAM)
          d_dw = 3'd4; // RULE_12
      end
      CMD_SECTOR_ERASE_A, CMD_SECTOR_ERASE_B:
      begin
        d_addr = 1'b1; // RULE_20 RULE_14
        d_kind = OP_SECTOR_ERASE;
      end
      CMD_SMALL_BLOCK_ERASE, CMD_LARGE_BLOCK_ERASE:
      begin
        d_addr = 1'b1; // RULE_20 RULE_14
        d_kind = (opc_now == CMD_SMALL_BLOCK_ERASE) ? OP_SMALL_ERASE : OP_LARGE_ERASE;
      end
      CMD_WHOLE_ARRAY_ERASE_A, CMD_WHOLE_ARRAY_ERASE_B:
      begin
        d_fire = 1'b1; // RULE_21 RULE_14
        d_kind = OP_WHOLE_ERASE;
      end
      CMD_WRITE_ENABLE, CMD_WRITE_DISABLE:
      begin
        d_fire = 1'b1; // RULE_21
        d_kind = (opc_now == CMD_WRITE_ENABLE) ? OP_WRITE_ENABLE : OP_WRITE_DISABLE;
      end
      CMD_STATUS_READ, CMD_FUNCTION_READ:
      begin
        d_rd = 1'b1; // RULE_22
        d_src = (opc_now == CMD_STATUS_READ) ? SRC_STATUS : SRC_FUNCTION;
      end
      CMD_STATUS_WRITE, CMD_FUNCTION_WRITE:
      begin
        d_wdata = 1'b1; // RULE_22
        d_kind = (opc_now == CMD_STATUS_WRITE) ? OP_STATUS_WRITE : OP_FUNCTION_WRITE;
      end
      default:
        d_kind = OP_READ;
    endcase
  end

  // address shifting, read launch and outgoing events
  always_comb
  begin
    if (dtr_q && !first_q)
    begin
      sh_n = shin(shin(sh_q, neg_q, aw_q), i_io, aw_q); // RULE_11
      cnt_n = cnt_q + {1'b0, aw_q, 1'b0};
    end
    else
    begin
      sh_n = shin(sh_q, i_io, aw_q);
      cnt_n = cnt_q + {2'b00, aw_q};
    end
    addr_done = (st_q == LS_ADDR) && !dtr_q && (cnt_n == ADDR_BITS);
    dtr_tail = (st_q == LS_ADDR) && dtr_q && (cnt_n == ADDR_BITS - {2'b00, aw_q});
    dum_end = (st_q == LS_DUMMY) && (cnt_q == {1'b0, dum_q} - 5'd1);
    rd_start = (addr_done && rd_q && (dum_q == 4'h0)) || dum_end || (cmd_done && d_rd && !d_addr);
    rd_addr = (st_q == LS_ADDR) ? sh_n : addr_q;
    src_eff = (st_q == LS_CMD) ? d_src : src_q;
    dw_eff = (st_q == LS_CMD) ? d_dw : dw_q;
    step_eff = (dtr_q && (st_q != LS_CMD)) ? {1'b0, dw_eff, 1'b0} : {2'b00, dw_eff};
    status_byte = {stat_hi_q, wel_q, ls2_q[3]};
    case (src_eff)
      SRC_STATUS: byte_src = status_byte;
      SRC_FUNCTION: byte_src = func_q;
      default: byte_src = ERASED_BYTE; // RULE_15
    endcase
    wrap_m = {i_wrap_len_sync(ls2_q[1:0]), 3'b111};
    wrap_next = {rd_addr[23:6], (rd_addr[5:0] & ~wrap_m) | (6'(rd_addr[5:0] + 6'd1) & wrap_m)};
    if (!ls2_q[2])
      wrap_next = rd_addr + 24'd1;
    wb_n = 8'(shin(sh_q, i_io, dw_q));
    wb_done = (st_q == LS_WDATA) && (cnt_q + {2'b00, dw_q} == BYTE_BITS);
    fire = 1'b0;
    fire_kind = kind_q;
    fire_addr = 24'h000000;
    fire_data = 8'h00;
    if (cmd_done && d_fire)
    begin
      fire = 1'b1;
      fire_kind = d_kind;
    end
    else if (addr_done && !rd_q && (kind_q != OP_PROGRAM))
    begin
      fire = 1'b1; // RULE_14
      case (kind_q)
        OP_SECTOR_ERASE: fire_addr = sh_n & SECTOR_MASK;
        OP_SMALL_ERASE: fire_addr = sh_n & SMALL_BLOCK_MASK;
        default: fire_addr = sh_n & LARGE_BLOCK_MASK;
      endcase
    end
    else if (rd_start && (src_eff == SRC_ARRAY) && (st_q != LS_CMD))
    begin
      fire = 1'b1;
      fire_kind = OP_READ;
      fire_addr = rd_addr;
      fire_data = ERASED_BYTE;
    end
    else if ((st_q == LS_RDATA) && (rem_q == 5'd0) && (src_q == SRC_ARRAY))
    begin
      fire = 1'b1;
      fire_kind = OP_READ;
      fire_addr = addr_q;
      fire_data = ERASED_BYTE;
    end
    else if (wb_done)
    begin
      fire = 1'b1;
      fire_addr = (kind_q == OP_PROGRAM) ? addr_q : 24'h000000;
      fire_data = wb_n;
    end
  end

  function automatic logic [2:0] i_wrap_len_sync(input logic [1:0] len);
    i_wrap_len_sync = {len == 2'd3, len[1], len != 2'd0}; // RULE_16
  endfunction

  // interface mode, write latch and registers survive deselect
  always_ff @(posedge i_sck or posedge rst_q)
  begin
    if (rst_q)
    begin
      qpi_q <= 1'b0; // RULE_09
      wel_q <= 1'b0;
      arm_q <= 1'b0;
      stat_hi_q <= STATUS_HI_RESET;
      func_q <= FUNCTION_RESET;
      ev_tgl_q <= 1'b0;
      ev_kind_q <= OP_READ;
      ev_addr_q <= 24'h000000;
      ev_data_q <= 8'h00;
    end
    else if (!i_cs_n)
    begin
      if (cmd_done)
      begin
        arm_q <= (opc_now == CMD_RESET_ENABLE);
        if (opc_now == CMD_QUAD_MODE_ENTER)
          qpi_q <= 1'b1; // RULE_04 RULE_06 RULE_08
        else if (opc_now == CMD_QUAD_MODE_EXIT)
          qpi_q <= 1'b0; // RULE_05 RULE_06 RULE_08
        else if ((opc_now == CMD_RESET_DO) && arm_q)
        begin
          qpi_q <= 1'b0; // RULE_09
          wel_q <= 1'b0;
        end
        if (opc_now == CMD_WRITE_ENABLE)
          wel_q <= 1'b1;
        else if (opc_now == CMD_WRITE_DISABLE)
          wel_q <= 1'b0;
      end
      if (wb_done && (kind_q == OP_STATUS_WRITE))
        stat_hi_q <= wb_n[7:2];
      if (wb_done && (kind_q == OP_FUNCTION_WRITE))
        func_q <= wb_n;
      if (fire)
      begin
        ev_tgl_q <= ~ev_tgl_q;
        ev_kind_q <= fire_kind;
        ev_addr_q <= fire_addr;
        ev_data_q <= fire_data;
      end
    end
  end

  // per-frame sequencer; deselect throws away whatever was in flight
  always_ff @(posedge i_sck or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      st_q <= LS_CMD; // RULE_25 RULE_23
      cnt_q <= 5'd0;
      sh_q <= 24'h000000;
      addr_q <= 24'h000000;
      aw_q <= 3'd1;
      dw_q <= 3'd1;
      dtr_q <= 1'b0;
      first_q <= 1'b0;
      tail_q <= 1'b0;
      rd_q <= 1'b0;
      dum_q <= 4'h0;
      kind_q <= OP_READ;
      src_q <= SRC_ARRAY;
      ob_q <= 8'h00;
      rem_q <= 5'd0;
    end
    else
    begin
      if (rd_start)
      begin
        st_q <= LS_RDATA; // RULE_03
        ob_q <= byte_src;
        rem_q <= BYTE_BITS - step_eff;
        addr_q <= wrap_next;
      end
      case (st_q)
        LS_CMD:
        begin
          sh_q <= shin(sh_q, i_io, cw);
          cnt_q <= cnt_q + {2'b00, cw};
          if (cmd_done)
          begin
            cnt_q <= 5'd0;
            aw_q <= d_aw;
            dw_q <= d_dw;
            dtr_q <= d_dtr;
            dum_q <= d_dum;
            rd_q <= d_rd;
            kind_q <= d_kind;
            src_q <= d_src;
            first_q <= 1'b1;
            if (d_addr)
              st_q <= LS_ADDR;
            else if (d_wdata)
              st_q <= LS_WDATA;
            else if (!d_rd)
              st_q <= LS_IGNORE;
          end
        end
        LS_ADDR:
        begin
          sh_q <= sh_n;
          cnt_q <= cnt_n;
          first_q <= 1'b0;
          if (dtr_tail)
          begin
            st_q <= LS_DUMMY;
            tail_q <= 1'b1;
            cnt_q <= 5'd0;
          end
          else if (addr_done && !rd_start)
          begin
            addr_q <= sh_n;
            cnt_q <= 5'd0;
            if (rd_q)
              st_q <= LS_DUMMY;
            else if (kind_q == OP_PROGRAM)
              st_q <= LS_WDATA;
            else
              st_q <= LS_IGNORE;
          end
        end
        LS_DUMMY:
        begin
          cnt_q <= cnt_q + 5'd1;
          if (tail_q)
          begin
            addr_q <= shin(sh_q, neg_q, aw_q); // RULE_11
            tail_q <= 1'b0;
          end
        end
        LS_WDATA:
        begin
          sh_q <= shin(sh_q, i_io, dw_q); // RULE_12
          cnt_q <= cnt_q + {2'b00, dw_q};
          if (wb_done)
          begin
            cnt_q <= 5'd0;
            addr_q <= {addr_q[23:8], 8'(addr_q[7:0] + 8'd1)}; // RULE_13
            if (kind_q != OP_PROGRAM)
              st_q <= LS_IGNORE;
          end
        end
        LS_RDATA:
        begin
          if (rem_q == 5'd0)
          begin
            ob_q <= byte_src;
            rem_q <= BYTE_BITS - step_eff;
            addr_q <= wrap_next; // RULE_16
          end
          else
          begin
            ob_q <= ob_q << dw_q;
            rem_q <= rem_q - step_eff;
          end
        end
        LS_IGNORE:
          st_q <= LS_IGNORE;
        default:
          st_q <= LS_IGNORE;
      endcase
    end
  end

  // launch on the falling edge so the host samples a settled bit on the next rise
  always_ff @(negedge i_sck or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      o_io <= 4'h0;
      o_io_oe_n <= 4'hf; // RULE_23
    end
    else if (st_q == LS_RDATA)
    begin
      case (dw_q)
        3'd1:
        begin
          o_io <= {2'b00, ob_q[7], 1'b0}; // RULE_03 RULE_02
          o_io_oe_n <= 4'hd;
        end
        3'd2:
        begin
          o_io <= {2'b00, ob_q[7:6]}; // RULE_12
          o_io_oe_n <= 4'hc;
        end
        default:
        begin
          o_io <= ob_q[7:4]; // RULE_10
          o_io_oe_n <= 4'h0;
        end
      endcase
    end
    else
    begin
      o_io <= 4'h0;
      o_io_oe_n <= 4'hf;
    end
  end

endmodule // sfq_front_end
`default_nettype wire

/* File: dv/sfq_front_end_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module sfq_front_end_assertions
  import sfq_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic [3:0] o_io_oe_n,
  input wire logic o_op_valid,
  input wire sfq_op_type o_op_kind,
  input wire logic [23:0] o_op_addr,
  input wire logic [7:0] o_op_data,
  input wire logic o_quad_mode,
  input wire logic o_write_enabled
);
  logic [3:0] idle_q;
  // sys cycles since the host last selected the device
  always_ff @(posedge i_clk_sys)
    if (!i_cs_n)
      idle_q <= 4'h0;
    else if (idle_q != 4'hf)
      idle_q <= idle_q + 4'h1;
  AST_DESEL_FLOAT: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_cs_n && $past(i_cs_n) |-> o_io_oe_n == 4'hf)
    else $error("pins driven while deselected");
  AST_EVENT_IN_FRAME: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    o_op_valid |-> idle_q < 4'h6)
    else $error("event long after deselect");
  AST_OE_SHAPE: assert property (@(posedge i_sck) disable iff (i_cs_n)
    o_io_oe_n inside {4'hf, 4'hd, 4'hc, 4'h0})
    else $error("bad output line set");
  AST_QUAD_OE: assert property (@(posedge i_sck) disable iff (i_cs_n)
    o_quad_mode |-> o_io_oe_n inside {4'hf, 4'h0})
    else $error("partial lines in quad mode");
  AST_ERASE_ALIGN: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    o_op_valid |-> (o_op_kind != OP_SECTOR_ERASE || o_op_addr[11:0] == 12'h000)
    && (o_op_kind != OP_SMALL_ERASE || o_op_addr[14:0] == 15'h0000)
    && (o_op_kind != OP_LARGE_ERASE || o_op_addr[15:0] == 16'h0000))
    else $error("erase base not aligned");
  AST_READ_ONES: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    o_op_valid && o_op_kind == OP_READ |-> o_op_data == ERASED_BYTE)
    else $error("read event data not erased value");
  AST_WEL_SET: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    o_op_valid && o_op_kind == OP_WRITE_ENABLE |-> ##[0:4] o_write_enabled)
    else $error("write latch not set");
  AST_WEL_CLR: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    o_op_valid && o_op_kind == OP_WRITE_DISABLE |-> ##[0:4] !o_write_enabled)
    else $error("write latch not cleared");
  AST_RST_CLEAR: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    $fell(i_srst) |-> !o_quad_mode && !o_write_enabled && !o_op_valid)
    else $error("state survived reset");
endmodule // sfq_front_end_assertions
bind sfq_front_end sfq_front_end_assertions sfq_front_end_assertions_i (.i_clk_sys,
  .i_srst, .i_sck, .i_cs_n, .o_io_oe_n, .o_op_valid, .o_op_kind, .o_op_addr,
  .o_op_data, .o_quad_mode, .o_write_enabled);
`default_nettype wire

/* File: dv/sfq_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// host controller: sck runs only in frames, 12 ns period
module sfq_host_model (
  output logic o_sck,
  output logic o_cs_n,
  output logic [3:0] o_io,
  input wire logic [3:0] i_io
);
  logic cpol, dtr;
  // deselected, clock at rest
  initial
  begin
    cpol = 1'b0;
    dtr = 1'b0;
    o_sck = 1'b0;
    o_cs_n = 1'b0;
    o_io = 4'hc;
    // a true rise of select idles the device pins
    #1 o_cs_n = 1'b1;
  end
  // released lines flip so stale data never passes
  task clk1(input logic [3:0] v, input logic [3:0] m);
    o_sck = 1'b0;
    o_io = (v & ~m) | (~o_io & m);
    #6 o_sck = 1'b1;
    #6;
  endtask
  task open;
    o_sck = cpol;
    o_io = 4'hc;
    #6 o_cs_n = 1'b0;
    #6;
  endtask
  task close;
    o_sck = cpol;
    #6 o_cs_n = 1'b1;
    o_io = ~o_io;
  endtask
  // msb first, w lines per clock
  task send(input int w, input logic [23:0] v, input int n);
    logic [3:0] u;
    for (int i = n - w; i >= 0; i -= w)
    begin
      u = (w == 4) ? 4'h0 : 4'hc;
      for (int b = 0; b < w; b++)
        u[b] = v[i + b];
      if (dtr && i < n - w)
      begin
        o_io = u;
        #3 o_sck = ~o_sck;
        #3;
      end
      else
        clk1(u, 4'h0);
    end
  endtask
  task rx(input int w, output logic [7:0] r);
    r = 8'h00;
    for (int i = 0; i < 8; i += w)
    begin
      clk1(4'hc, (w == 4) ? 4'hf : 4'h3);
      if (w == 1)
        r = {r[6:0], i_io[1]};
      else if (w == 2)
        r = {r[5:0], i_io[1:0]};
      else
        r = {r[3:0], i_io};
    end
  endtask
endmodule // sfq_host_model
`default_nettype wire

/* File: dv/sfq_front_end_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module sfq_front_end_tb;
  import sfq_pkg::*;
  localparam logic [7:0] EC [6] = '{CMD_SECTOR_ERASE_A, CMD_SECTOR_ERASE_B,
    CMD_SMALL_BLOCK_ERASE, CMD_LARGE_BLOCK_ERASE, CMD_WHOLE_ARRAY_ERASE_A,
    CMD_WHOLE_ARRAY_ERASE_B};
  localparam sfq_op_type EK [6] = '{OP_SECTOR_ERASE, OP_SECTOR_ERASE, OP_SMALL_ERASE,
    OP_LARGE_ERASE, OP_WHOLE_ERASE, OP_WHOLE_ERASE};
  localparam logic [23:0] EM [6] = '{SECTOR_MASK, SECTOR_MASK, SMALL_BLOCK_MASK,
    LARGE_BLOCK_MASK, 24'h000000, 24'h000000};
  localparam logic [7:0] PC [3] = '{CMD_PAGE_PROGRAM, CMD_QUAD_PAGE_PROGRAM_A,
    CMD_QUAD_PAGE_PROGRAM_B};
  localparam logic [7:0] RC [7] = '{CMD_NORMAL_READ, CMD_FAST_READ,
    CMD_DUAL_OUTPUT_READ, CMD_QUAD_OUTPUT_READ, CMD_DUAL_IO_READ, CMD_QUAD_IO_READ,
    CMD_DTR_QUAD_READ};
  localparam int RA [7] = '{1, 1, 1, 1, 2, 4, 4};
  localparam int RD [7] = '{0, DUMMY_FAST, DUMMY_FAST, DUMMY_FAST, DUMMY_DUAL_IO,
    DUMMY_QUAD_IO, DUMMY_DTR_QUAD};
  localparam int RW [7] = '{1, 1, 2, 4, 2, 4, 4};
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic busy = 1'b0;
  logic wrap_en = 1'b0;
  logic [1:0] wrap_len = 2'h0;
  logic sck, cs_n, op_valid, qm, wel;
  logic [3:0] hio, dio, doe_n, pad;
  sfq_op_type kind, ev_kind;
  logic [23:0] addr, ev_addr, ra;
  logic [7:0] data, ev_data, rb;
  int ev_n, mismatches, check_count, seed;
  // device wins where it drives
  assign pad = (~doe_n & dio) | (doe_n & hio);
  always #20 clk_sys = ~clk_sys;
  sfq_host_model sfq_host_model_i (.o_sck(sck), .o_cs_n(cs_n), .o_io(hio), .i_io(pad));
  sfq_front_end sfq_front_end_i (.i_clk_sys(clk_sys), .i_srst(srst), .i_ce(1'b1),
    .i_sck(sck), .i_cs_n(cs_n), .i_io(pad), .o_io(dio), .o_io_oe_n(doe_n),
    .i_busy(busy), .i_wrap_en(wrap_en), .i_wrap_len(wrap_len), .o_op_valid(op_valid),
    .o_op_kind(kind), .o_op_addr(addr), .o_op_data(data), .o_quad_mode(qm),
    .o_write_enabled(wel));
  // first event of a frame, sampled mid-cycle
  always @(negedge clk_sys)
    if (op_valid === 1'b1)
    begin
      if (ev_n == 0)
      begin
        ev_kind = kind;
        ev_addr = addr;
        ev_data = data;
      end
      ev_n++;
    end
  function automatic logic [7:0] stat_exp(input logic wl, input logic b);
    return {STATUS_HI_RESET, wl, b};
  endfunction
  task chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tx(input int w, input logic [23:0] v, input int n);
    sfq_host_model_i.send(w, v, n);
  endtask
  task beg(input int w, input logic [7:0] c);
    ev_n = 0;
    sfq_host_model_i.open;
    tx(w, {16'h0000, c}, 8);
  endtask
  // gap lets events cross into the sys domain
  task fin;
    sfq_host_model_i.close;
    #400;
  endtask
  task cmd(input int w, input logic [7:0] c);
    beg(w, c);
    fin;
  endtask
  task rd(input int ow, input logic [7:0] c, input int aw, input int nd, input int dw);
    ra = 24'($random(seed));
    beg(ow, c);
    sfq_host_model_i.dtr = (c == CMD_DTR_QUAD_READ);
    tx(aw, ra, 24);
    sfq_host_model_i.dtr = 1'b0;
    repeat (nd) sfq_host_model_i.clk1(4'hc, (ow == 4) ? 4'hf : 4'h3);
    // first event crosses before burst events follow
    #200;
    repeat (2)
    begin
      sfq_host_model_i.rx(dw, rb);
      chk(rb, ERASED_BYTE);
    end
    fin;
    chk(ev_kind, OP_READ);
    chk(ev_addr, ra);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, run needs well under this
  initial
  begin
    #200000;
    mismatches++;
    stop_test;
  end
  initial
  begin
    seed = 44605;
    repeat (8) @(negedge clk_sys);
    srst = 1'b0;
    repeat (3) @(negedge clk_sys);
    for (int m = 0; m < 2; m++)
    begin
      @(negedge clk_sys);
      busy = 1'($random(seed));
      wrap_en = 1'($random(seed));
      wrap_len = 2'($random(seed));
      sfq_host_model_i.cpol = m[0];
      cmd(1, CMD_WRITE_ENABLE);
      chk(ev_kind, OP_WRITE_ENABLE);
      chk(wel, 1'b1);
      beg(1, CMD_STATUS_READ);
      sfq_host_model_i.rx(1, rb);
      fin;
      chk(rb, stat_exp(1'b1, busy));
      cmd(1, CMD_WRITE_DISABLE);
      chk(wel, 1'b0);
    end
    $display("test modes done");
    for (int i = 0; i < 6; i++)
    begin
      ra = 24'($random(seed));
      beg(1, EC[i]);
      if (i < 4)
        tx(1, ra, 24);
      fin;
      chk(ev_kind, EK[i]);
      if (i < 4)
        chk(ev_addr, ra & EM[i]);
    end
    for (int i = 0; i < 3; i++)
    begin
      ra = 24'($random(seed));
      rb = 8'($random(seed));
      beg(1, PC[i]);
      tx(1, ra, 24);
      tx((i > 0) ? 4 : 1, {16'h0000, rb}, 8);
      fin;
      chk(ev_kind, OP_PROGRAM);
      chk({ev_data, ev_addr[15:0]}, {rb, ra[15:0]});
    end
    for (int i = 0; i < 7; i++)
      rd(1, RC[i], RA[i], RD[i], RW[i]);
    $display("test ops done");
    cmd(1, CMD_QUAD_MODE_ENTER);
    chk(qm, 1'b1);
    cmd(4, CMD_WRITE_ENABLE);
    chk(wel, 1'b1);
    beg(4, CMD_STATUS_READ);
    sfq_host_model_i.rx(4, rb);
    fin;
    chk(rb, stat_exp(1'b1, busy));
    rd(4, CMD_FAST_READ, 4, DUMMY_QPI_FAST, 4);
    cmd(4, CMD_QUAD_MODE_EXIT);
    chk(qm, 1'b0);
    $display("test quad done");
    cmd(1, CMD_QUAD_MODE_ENTER);
    cmd(4, CMD_WRITE_ENABLE);
    cmd(4, CMD_RESET_ENABLE);
    cmd(4, CMD_RESET_DO);
    chk({qm, wel}, 2'b00);
    cmd(1, CMD_QUAD_MODE_ENTER);
    chk(qm, 1'b1);
    @(negedge clk_sys);
    srst = 1'b1;
    repeat (2) @(negedge clk_sys);
    srst = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk(qm, 1'b0);
    // cut frame: seven bits of write enable
    ev_n = 0;
    sfq_host_model_i.open;
    tx(1, 24'h000003, 7);
    fin;
    chk({ev_n[3:0], wel}, 5'h00);
    $display("test resets done");
    stop_test;
  end
endmodule // sfq_front_end_tb
`default_nettype wire
